// >>> dv/lcis_src.sv
// Sixteen sources, registered on hclk like the real on-chip producers.
`timescale 1ns/1ps
`default_nettype none
module lcis_src (
  input wire logic hclk,
  input wire logic [15:0] pattern,
  output logic [15:0] source_in
);
  always_ff @(posedge hclk) source_in <= pattern;
endmodule : lcis_src
`default_nettype wire

// >>> dv/lcis_sva.sv
// Checker on the top ports of the select stage.
// Assumes hready is fed back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module lcis_sva (
  input wire logic hclk, hresetn, hsel, hwrite, hready,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [15:0] source_in,
  input wire logic first_data_line, second_data_line, third_data_line, fourth_data_line
);
  logic [7:0] s0, s1, wa;
  logic wp;
  // Shadow copies of both select registers, rebuilt from bus writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {s0, s1, wa, wp} <= '0;
    end else begin
      if (wp && wa == 8'h00) s0 <= hwdata[7:0];
      if (wp && wa == 8'h04) s1 <= hwdata[7:0];
      if (hready) {wp, wa} <= {hsel && hwrite && htrans == 2'h2, haddr[7:0]};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_line_one: assert property (first_data_line == source_in[s0[2:0]]) else $error("line 1");
  a_line_two: assert property (second_data_line == source_in[4'h4 + {1'b0, s0[6:4]}])
    else $error("line 2");
  a_line_three: assert property (third_data_line == source_in[{1'b1, s1[2:0]}]) else $error("line 3");
  a_four_high: assert property (s1[6] |-> fourth_data_line == source_in[s1[5:4]]) else $error("l4");
  a_four_low: assert property (!s1[6] |-> fourth_data_line == source_in[{2'h3, s1[5:4]}]) else $error("l4");
  a_unused_zero: assert property (wa != 8'h08 |-> !hrdata[7] && !hrdata[3]) else $error("bits");
  a_write_now: assert property (wp && wa == 8'h04 |=> third_data_line == source_in[{1'b1, $past(hwdata[2:0])}])
    else $error("late");
  a_write_one: assert property (wp && wa == 8'h00 |=> first_data_line == source_in[$past(hwdata[2:0])])
    else $error("late");
endmodule : lcis_sva
bind lcis_top lcis_sva u_sva (.hclk, .hresetn, .hsel, .hwrite, .hready, .htrans, .haddr, .hwdata, .hrdata,
  .source_in, .first_data_line, .second_data_line, .third_data_line, .fourth_data_line);
`default_nettype wire

// >>> dv/tb_top.sv
// Bench: AHB-Lite master, source model and a shadow of the select codes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, l1, l2, l3, l4;
  logic [1:0] htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q, seed = 32'haf33_bb12;
  logic [15:0] pat = '0, source_in;
  logic [7:0] v;
  int failures = 0, n_tests = 0, sel[4];
  always #12.5 hclk = ~hclk;
  lcis_src SRC (.hclk, .pattern(pat), .source_in);
  lcis_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(lcis_pkg::HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .source_in, .first_data_line(l1),
    .second_data_line(l2), .third_data_line(l3), .fourth_data_line(l4));
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ready();
    int k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      stop_test();
    end
  endtask : ready
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= lcis_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0000_00, a};
    ready();
    htrans <= 2'h0;
    hwdata <= d;
    ready();
    q = hrdata;
  endtask : xfer
  task automatic lines();
    @(negedge hclk);
    chk("line1", l1, source_in[sel[0]]);
    chk("line2", l2, source_in[4 + sel[1]]);
    chk("line3", l3, source_in[8 + sel[2]]);
    chk("line4", l4, source_in[(12 + sel[3]) % 16]);
    @(posedge hclk);
  endtask : lines
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, 8'h00, '0);
    chk("reset", q, '0);
    xfer(0, 8'h0c, '0);
    chk("unmapped", q, '0);
    for (int i = 0; i < 8; i++) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      v = {seed[7], i[2:0], seed[3], i[2:0]};
      sel = '{i, i, i, i};
      xfer(1, 8'h00, {seed[31:8], v});
      xfer(1, 8'h04, {seed[31:8], v});
      lines();
      pat <= seed[15:0];
      @(posedge hclk);
      lines();
      xfer(0, 8'h04, '0);
      chk("sel", q, {24'h0000_00, v & lcis_pkg::SEL_IMPL_MASK});
      xfer(0, 8'h00, '0);
      chk("sel12", q, {24'h0000_00, v & lcis_pkg::SEL_IMPL_MASK});
      xfer(0, 8'h08, '0);
      chk("status", q, {28'h000_0000, source_in[(12 + i) % 16], source_in[8 + i], source_in[4 + i], source_in[i]});
      $display("test code %0d done", i);
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> rtl/lcis_pkg.sv
// Package for the logic cell input select stage: register map, field layout and source mapping.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package lcis_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_ONE_TWO_SEL_OFFSET = 8'h00;
  localparam logic [7:0] LINE_THREE_FOUR_SEL_OFFSET = 8'h04;
  localparam logic [7:0] LINE_STATUS_OFFSET = 8'h08;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 4;
  localparam int FIELD_WIDTH = 3;
  localparam logic [7:0] SEL_IMPL_MASK = 8'h77;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Source base per data line: the code adds to it modulo sixteen
  // ----------------------------------------------------------------
  localparam logic [3:0] LINE1_BASE = 4'h0;
  localparam logic [3:0] LINE2_BASE = 4'h4;
  localparam logic [3:0] LINE3_BASE = 4'h8;
  localparam logic [3:0] LINE4_BASE = 4'hc;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef struct packed {
    logic [2:0] fourth_line_source_sel;
    logic [2:0] third_line_source_sel;
    logic [2:0] second_line_source_sel;
    logic [2:0] first_line_source_sel;
  } lcis_sel_s;

endpackage : lcis_pkg

// >>> rtl/lcis_top.sv
// Logic cell input select stage: four register-steered eight-way muxes over sixteen sources.
// Assumes sources are synchronous to hclk, driven by on-chip logic of the same clock.
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module lcis_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Signal sources and selected data lines
  input wire logic [15:0] source_in,
  output logic first_data_line,
  output logic second_data_line,
  output logic third_data_line,
  output logic fourth_data_line
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [7:0] sel12_reg;
  logic [7:0] sel34_reg;
  logic [7:0] rd_word;
  logic [3:0] line_vec;
  lcis_pkg::lcis_sel_s sel;

  wire logic take = hsel && hready && (htrans == lcis_pkg::HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Select registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel12_reg <= lcis_pkg::SEL_RESET;
      sel34_reg <= lcis_pkg::SEL_RESET;
    end else if (wr_pend_reg) begin
      if (addr_reg == lcis_pkg::LINE_ONE_TWO_SEL_OFFSET) begin
        sel12_reg <= hwdata[7:0] & lcis_pkg::SEL_IMPL_MASK;
      end
      if (addr_reg == lcis_pkg::LINE_THREE_FOUR_SEL_OFFSET) begin
        sel34_reg <= hwdata[7:0] & lcis_pkg::SEL_IMPL_MASK;
      end
    end
  end

  assign sel.first_line_source_sel = sel12_reg[lcis_pkg::LOW_FIELD_LSB +: lcis_pkg::FIELD_WIDTH];
  assign sel.second_line_source_sel = sel12_reg[lcis_pkg::HIGH_FIELD_LSB +: lcis_pkg::FIELD_WIDTH];
  assign sel.third_line_source_sel = sel34_reg[lcis_pkg::LOW_FIELD_LSB +: lcis_pkg::FIELD_WIDTH];
  assign sel.fourth_line_source_sel = sel34_reg[lcis_pkg::HIGH_FIELD_LSB +: lcis_pkg::FIELD_WIDTH];

  // ----------------------------------------------------------------
  // Source multiplexers
  // ----------------------------------------------------------------
  // Each line picks base plus code, wrapping at sixteen; line four's wrap gives 100->in0.
  // Pure combinational paths so a new select or source shows on the line in the same cycle.
  always_comb begin
    line_vec[0] = source_in[lcis_pkg::LINE1_BASE + {1'b0, sel.first_line_source_sel}];
    line_vec[1] = source_in[lcis_pkg::LINE2_BASE + {1'b0, sel.second_line_source_sel}];
    line_vec[2] = source_in[lcis_pkg::LINE3_BASE + {1'b0, sel.third_line_source_sel}];
    line_vec[3] = source_in[4'(lcis_pkg::LINE4_BASE + {1'b0, sel.fourth_line_source_sel})];
  end

  assign first_data_line = line_vec[0];
  assign second_data_line = line_vec[1];
  assign third_data_line = line_vec[2];
  assign fourth_data_line = line_vec[3];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    case (addr_reg)
      lcis_pkg::LINE_ONE_TWO_SEL_OFFSET: rd_word = sel12_reg;
      lcis_pkg::LINE_THREE_FOUR_SEL_OFFSET: rd_word = sel34_reg;
      lcis_pkg::LINE_STATUS_OFFSET: rd_word = {4'h0, line_vec};
      default: rd_word = 8'h00;
    endcase
  end

  assign hrdata = {24'h00_0000, rd_word};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : lcis_top

`default_nettype wire
